// ==== testbench/ttcbg_pin_model.sv ====
// Purpose: Drives the gate, count, clock and trigger pins of the timers
// Assumes: Pins idle high; they are asynchronous to sys_clk
// Notes:   Pulses of 2 clocks low and 2 high are the fastest the block takes
`timescale 1ns/1ps
module ttcbg_pin_model
  import ttcbg_pkg::*;
(
  input  wire logic sys_clk,
  output logic      ext_pin_zero,
  output logic      ext_pin_one,
  output logic      t0_count_pin,
  output logic      t1_count_pin,
  output logic      third_ext_clock_pin,
  output logic      third_trigger_pin
);
  logic [NPINS-1:0] pin_q;

  assign ext_pin_zero        = pin_q[PIN_GATE0];
  assign ext_pin_one         = pin_q[PIN_GATE1];
  assign t0_count_pin        = pin_q[PIN_CNT0];
  assign t1_count_pin        = pin_q[PIN_CNT1];
  assign third_ext_clock_pin = pin_q[PIN_CLK2];
  assign third_trigger_pin   = pin_q[PIN_TRIG2];

  initial pin_q = 6'h3F;

  task automatic set_level(input int idx, input logic val);
    @(posedge sys_clk);
    pin_q[idx] <= val;
  endtask : set_level

  // One falling edge per event; hold sets how promptly events follow
  task automatic pulse(input int idx, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      pin_q[idx] <= 1'b0;
      repeat (hold) @(posedge sys_clk);
      pin_q[idx] <= 1'b1;
      repeat (hold - 1) @(posedge sys_clk);
    end
  endtask : pulse
endmodule : ttcbg_pin_model

// ==== testbench/ttcbg_top_bench.sv ====
// Purpose: Register-level tests of the three timers and the baud source
// Assumes: Register port answers with read data one cycle after the strobe
// Notes:   Counter function is used where exact counts are needed
`timescale 1ns/1ps
module ttcbg_top_bench
  import ttcbg_pkg::*;
;
  logic              sys_clk, sys_rst, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic              p_g0, p_g1, p_c0, p_c1, p_clk2, p_trig;
  logic              t0_overflow, t1_overflow, t2_ovf, t2_ext, rx_tick, tx_tick;
  int                err_total, check_count, cyc, tx_n, rx_n, c1, c2;
  int                tx0, rx0, r1_n;
  logic              t1_roll;
  logic [7:0]        lo, hi, ex, v;
  logic [3:0]        lo_off;

  ttcbg_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_pin_zero(p_g0), .ext_pin_one(p_g1),
    .t0_count_pin(p_c0), .t1_count_pin(p_c1), .third_ext_clock_pin(p_clk2),
    .third_trigger_pin(p_trig), .t0_overflow(t0_overflow),
    .t1_overflow(t1_overflow), .t2_overflow_flag(t2_ovf),
    .t2_ext_flag(t2_ext), .t1_rollover_pulse(t1_roll),
    .rx_baud_tick(rx_tick),
    .tx_baud_tick(tx_tick));

  ttcbg_pin_model u_pins (.sys_clk(sys_clk), .ext_pin_zero(p_g0),
    .ext_pin_one(p_g1), .t0_count_pin(p_c0), .t1_count_pin(p_c1),
    .third_ext_clock_pin(p_clk2), .third_trigger_pin(p_trig));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Updated late in the time step so waiting tasks see a stable count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (tx_tick === 1'b1) tx_n <= tx_n + 1;
    if (rx_tick === 1'b1) rx_n <= rx_n + 1;
    if (t1_roll === 1'b1) r1_n <= r1_n + 1;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [7:0] mk, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e & mk, reg_rdata & mk);
  endtask : rd

  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask : settle

  // Run bit stays clear while counts and reloads are loaded
  task automatic third_setup(input logic [7:0] ctl, input logic [15:0] cnt,
                             input logic [15:0] cap);
    wr(OFF_THIRD_CTRL, ctl & 8'hFB);
    wr(OFF_THIRD_LOW, cnt[7:0]);
    wr(OFF_THIRD_HIGH, cnt[15:8]);
    wr(OFF_RCAP_LOW, cap[7:0]);
    wr(OFF_RCAP_HIGH, cap[15:8]);
    wr(OFF_THIRD_CTRL, ctl | 8'h04);
  endtask : third_setup

  task automatic wait_tick(output int c);
    int n0;
    n0 = tx_n;
    for (int i = 0; i < 300 && tx_n == n0; i++) @(posedge sys_clk);
    c = cyc;
  endtask : wait_tick

  initial begin
    #(25ns * 60000);
    err_total++;
    close_out();
  end

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {err_total, check_count, cyc, tx_n, rx_n, r1_n} = '0;
    sys_rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wr(4'hC, 8'hFF);
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00, 8'hFF, "reset value");
    for (int t = 0; t < 2; t++) begin
      lo_off = t ? OFF_T1_LOW : OFF_T0_LOW;
      for (int m = 0; m < 3; m++) begin
        lo = (m == 2) ? 8'hFF : 8'hFE;
        hi = (m == 2) ? 8'hA5 : 8'hFF;
        ex = (m == 2) ? 8'hA6 : 8'h00;
        wr(OFF_TIMER_CTRL, 8'h00);
        wr(OFF_TIMER_MODE, 8'((4 + m) << (4 * t)));
        wr(lo_off, lo);
        wr(lo_off + 4'h1, hi);
        wr(OFF_TIMER_CTRL, t ? 8'h04 : 8'h01);
        rd(lo_off, lo, 8'hFF, "count low after run");
        rd(lo_off + 4'h1, hi, 8'hFF, "count high after run");
        u_pins.pulse(t ? PIN_CNT1 : PIN_CNT0, 2, 4);
        settle();
        rd(lo_off, ex, (m == 0) ? 8'h1F : 8'hFF, "count low");
        rd(lo_off + 4'h1, (m == 2) ? hi : 8'h00, 8'hFF, "count high");
        chk("overflow flag", 8'h01, {7'h0, t ? t1_overflow : t0_overflow});
      end
      wr(OFF_TIMER_CTRL, 8'h00);
      wr(OFF_TIMER_MODE, 8'(8'h0D << (4 * t)));
      wr(lo_off, 8'h00);
      wr(OFF_TIMER_CTRL, t ? 8'h04 : 8'h01);
      u_pins.set_level(t ? PIN_GATE1 : PIN_GATE0, 1'b0);
      settle();
      u_pins.pulse(t ? PIN_CNT1 : PIN_CNT0, 2, 4);
      settle();
      rd(lo_off, 8'h00, 8'hFF, "gated count");
      u_pins.set_level(t ? PIN_GATE1 : PIN_GATE0, 1'b1);
      settle();
      u_pins.pulse(t ? PIN_CNT1 : PIN_CNT0, 2, 4);
      settle();
      rd(lo_off, 8'h02, 8'hFF, "open gate count");
      wr(OFF_TIMER_CTRL, 8'h00);
      u_pins.pulse(t ? PIN_CNT1 : PIN_CNT0, 1, 4);
      settle();
      rd(lo_off, 8'h02, 8'hFF, "stopped count");
    end
    // Timer 1 rolled over once in each of its three mode runs
    chk("timer 1 rollovers", 8'h03, 8'(r1_n));
    wr(OFF_TIMER_MODE, 8'h70);
    wr(OFF_T1_LOW, 8'h10);
    wr(OFF_TIMER_CTRL, 8'h04);
    u_pins.pulse(PIN_CNT1, 2, 4);
    settle();
    rd(OFF_T1_LOW, 8'h10, 8'hFF, "timer 1 held");
    wr(OFF_TIMER_CTRL, 8'h00);
    wr(OFF_TIMER_MODE, 8'h57);
    wr(OFF_T0_LOW, 8'hFE);
    wr(OFF_T0_HIGH, 8'hFF);
    wr(OFF_T1_LOW, 8'h00);
    wr(OFF_TIMER_CTRL, 8'h05);
    u_pins.pulse(PIN_CNT0, 2, 4);
    settle();
    rd(OFF_T0_LOW, 8'h00, 8'hFF, "split low byte");
    chk("split low flag", 8'h01, {7'h0, t0_overflow});
    chk("split high flag", 8'h01, {7'h0, t1_overflow});
    u_pins.pulse(PIN_CNT1, 3, 2);
    settle();
    rd(OFF_T1_LOW, 8'h03, 8'hFF, "timer 1 beside split");
    wr(OFF_TIMER_MODE, 8'h77);
    u_pins.pulse(PIN_CNT1, 2, 4);
    settle();
    rd(OFF_T1_LOW, 8'h03, 8'hFF, "timer 1 parked");
    third_setup(8'h02, 16'hFFFF, 16'h1234);
    u_pins.pulse(PIN_CLK2, 1, 4);
    settle();
    rd(OFF_THIRD_LOW, 8'h34, 8'hFF, "reload low");
    rd(OFF_THIRD_HIGH, 8'h12, 8'hFF, "reload high");
    chk("third overflow", 8'h01, {7'h0, t2_ovf});
    third_setup(8'h0A, 16'h0050, 16'h1234);
    u_pins.pulse(PIN_TRIG2, 1, 4);
    settle();
    rd(OFF_THIRD_LOW, 8'h34, 8'hFF, "trigger reload");
    chk("trigger flag", 8'h01, {7'h0, t2_ext});
    third_setup(8'h03, 16'h5566, 16'h0000);
    u_pins.pulse(PIN_TRIG2, 1, 4);
    settle();
    rd(OFF_RCAP_LOW, 8'h00, 8'hFF, "internal no capture");
    third_setup(8'h0B, 16'h5566, 16'h0000);
    u_pins.pulse(PIN_TRIG2, 1, 4);
    settle();
    rd(OFF_RCAP_LOW, 8'h66, 8'hFF, "capture low");
    rd(OFF_RCAP_HIGH, 8'h55, 8'hFF, "capture high");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h36 : (i == 1) ? 8'h26 : 8'h16;
      third_setup(v, 16'hFFFF, 16'hFFFF);
      tx0 = tx_n;
      rx0 = rx_n;
      u_pins.pulse(PIN_CLK2, 15, 2);
      settle();
      chk("ticks before 16", 8'h00, 8'(tx_n - tx0 + rx_n - rx0));
      u_pins.pulse(PIN_CLK2, 1, 2);
      settle();
      chk("tx ticks", {7'h0, v[4]}, 8'(tx_n - tx0));
      chk("rx ticks", {7'h0, v[5]}, 8'(rx_n - rx0));
      chk("baud no flag", 8'h00, {7'h0, t2_ovf});
    end
    third_setup(8'h34, 16'hFFFE, 16'hFFFE);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CLOCK_MODE, 8'(k));
      wait_tick(c1);
      wait_tick(c1);
      wait_tick(c2);
      chk("baud period", k ? 8'h20 : 8'h40, 8'(c2 - c1));
    end
    close_out();
  end
endmodule : ttcbg_top_bench

// ==== verilog/ttcbg_pkg.sv ====
// Purpose: Shared constants for the triple timer/counter and baud block
// Assumes: 8-bit register port, 40 MHz sys_clk taken as the oscillator
// Notes:   Offsets are word indices on the plain register port
package ttcbg_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFF_TIMER_MODE  = 4'h0;
  localparam logic [3:0] OFF_TIMER_CTRL  = 4'h1;
  localparam logic [3:0] OFF_T0_LOW      = 4'h2;
  localparam logic [3:0] OFF_T0_HIGH     = 4'h3;
  localparam logic [3:0] OFF_T1_LOW      = 4'h4;
  localparam logic [3:0] OFF_T1_HIGH     = 4'h5;
  localparam logic [3:0] OFF_THIRD_CTRL  = 4'h6;
  localparam logic [3:0] OFF_THIRD_LOW   = 4'h7;
  localparam logic [3:0] OFF_THIRD_HIGH  = 4'h8;
  localparam logic [3:0] OFF_RCAP_LOW    = 4'h9;
  localparam logic [3:0] OFF_RCAP_HIGH   = 4'hA;
  localparam logic [3:0] OFF_CLOCK_MODE  = 4'hB;

  // Timer mode register fields
  localparam int unsigned TM_MODE0_LSB = 0;
  localparam int unsigned TM_CT0_BIT   = 2;
  localparam int unsigned TM_GATE0_BIT = 3;
  localparam int unsigned TM_MODE1_LSB = 4;
  localparam int unsigned TM_CT1_BIT   = 6;
  localparam int unsigned TM_GATE1_BIT = 7;

  // Timer control register fields
  localparam int unsigned TC_RUN0_BIT = 0;
  localparam int unsigned TC_OVF0_BIT = 1;
  localparam int unsigned TC_RUN1_BIT = 2;
  localparam int unsigned TC_OVF1_BIT = 3;

  // Third timer control fields
  localparam int unsigned T2_CPRL_BIT = 0;
  localparam int unsigned T2_CT_BIT   = 1;
  localparam int unsigned T2_RUN_BIT  = 2;
  localparam int unsigned T2_EXEN_BIT = 3;
  localparam int unsigned T2_TXB_BIT  = 4;
  localparam int unsigned T2_RXB_BIT  = 5;
  localparam int unsigned T2_EXF_BIT  = 6;
  localparam int unsigned T2_OVF_BIT  = 7;

  localparam int unsigned CM_SIX_BIT = 0;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Oscillator clocks per machine cycle, less one
  localparam logic [3:0] MCYC_LAST_12 = 4'hB;
  localparam logic [3:0] MCYC_LAST_6  = 4'h5;
  // Overflows per serial bit, less one
  localparam logic [3:0] BAUD_DIV_LAST = 4'hF;

  // Pin indices of the synchroniser bank
  localparam int unsigned PIN_GATE0 = 0;
  localparam int unsigned PIN_GATE1 = 1;
  localparam int unsigned PIN_CNT0  = 2;
  localparam int unsigned PIN_CNT1  = 3;
  localparam int unsigned PIN_CLK2  = 4;
  localparam int unsigned PIN_TRIG2 = 5;
  localparam int unsigned NPINS     = 6;

  typedef enum logic [1:0] {
    TTCBG_M13   = 2'h0,
    TTCBG_M16   = 2'h1,
    TTCBG_M8AR  = 2'h2,
    TTCBG_SPLIT = 2'h3
  } ttcbg_mode_e;
endpackage : ttcbg_pkg

// ==== verilog/ttcbg_top.sv ====
// Purpose: Three timer/counters with split mode and a baud rate source
// Assumes: sys_clk is the oscillator; pins are asynchronous to it
// Notes:   Register port answers every access without wait states
//
// Summary of operation
// - Timers 0/1 count machine cycles or pin events, in four modes.
// - Mode 0 uses high byte plus low five bits of low byte.
// - Rollover from all ones to zero sets the overflow flag.
// - Count only while run is set and gate clear or gate pin high.
// - Setting run leaves the count bytes untouched.
// - Gate bits: bit 7 for timer 1, bit 3 for timer 0.
// - Mode 1 is mode 0 with all sixteen bits.
// - Mode 2: low byte counts, reloads from high byte on overflow.
// - Timer 1 in mode 3 holds its count.
// - Timer 0 mode 3: low byte is its own 8-bit counter.
// - Timer 0 mode 3: high byte times cycles using timer 1 run/flag.
// - Then timer 1 runs outside its mode 3, still a baud source.
// - Third timer control selects reload, capture or baud use.
// - Baud mode increments each state time or on its clock pin.
// - Serial bit rate is the third overflow rate over sixteen.
// - Internal baud rate is osc over n times reload distance.
// - Reload on overflow or trigger fall, capture on trigger fall only, if enabled.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module ttcbg_top
  import ttcbg_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              ext_pin_zero,
  input  wire logic              ext_pin_one,
  input  wire logic              t0_count_pin,
  input  wire logic              t1_count_pin,
  input  wire logic              third_ext_clock_pin,
  input  wire logic              third_trigger_pin,
  output logic                   t0_overflow,
  output logic                   t1_overflow,
  output logic                   t2_overflow_flag,
  output logic                   t2_ext_flag,
  output logic                   t1_rollover_pulse,
  output logic                   rx_baud_tick,
  output logic                   tx_baud_tick
);

  // Returns {carry, high, low} after one optional increment
  function automatic logic [16:0] tmr_step(input logic [1:0] mode,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo,
                                           input logic       inc);
    logic [5:0] l5;
    logic [8:0] h9;
    logic [16:0] w;
    logic [8:0] l9;
    l5 = {1'b0, lo[4:0]} + {5'h00, inc};
    h9 = {1'b0, hi} + {8'h00, l5[5]};
    w  = {1'b0, hi, lo} + {16'h0000, inc};
    l9 = {1'b0, lo} + {8'h00, inc};
    unique case (mode)
      TTCBG_M13:  tmr_step = {h9[8], h9[7:0], lo[7:5], l5[4:0]};
      TTCBG_M16:  tmr_step = w;
      TTCBG_M8AR: tmr_step = {l9[8], hi, (l9[8] ? hi : l9[7:0])};
      default:    tmr_step = {l9[8], hi, l9[7:0]};
    endcase
  endfunction : tmr_step

  // Pin synchronisers: three flops, a change counts when 2nd and 3rd agree
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] s1_q, s2_q, s3_q, flt_q, flt_d, fall_q;
  assign pin_raw = {third_trigger_pin, third_ext_clock_pin, t1_count_pin,
                    t0_count_pin, ext_pin_one, ext_pin_zero};
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      assign flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q[gi]   <= 1'b0;
          s2_q[gi]   <= 1'b0;
          s3_q[gi]   <= 1'b0;
          flt_q[gi]  <= 1'b0;
          fall_q[gi] <= 1'b0;
        end else begin
          s1_q[gi]   <= pin_raw[gi];
          s2_q[gi]   <= s1_q[gi];
          s3_q[gi]   <= s2_q[gi];
          flt_q[gi]  <= flt_d[gi];
          fall_q[gi] <= flt_q[gi] & ~flt_d[gi];
        end
      end
    end
  endgenerate

  // Register state
  logic [7:0]  timer_mode_register_q, tctl_q, t0lo_q, t0hi_q, t1lo_q, t1hi_q;
  logic [7:0]  t2ctl_q, cmode_q, rdata_q;
  logic [15:0] t2cnt_q, rcap_q;
  logic [3:0]  pre_q, bdiv_q;
  logic        t1roll_q, rxb_q, txb_q;

  // Write decode
  logic wr_timer_mode_register, wr_tctl, wr_t0lo, wr_t0hi, wr_t1lo, wr_t1hi;
  logic wr_t2ctl, wr_t2lo, wr_t2hi, wr_rclo, wr_rchi, wr_cmode;
  assign wr_timer_mode_register  = reg_wr && (reg_addr == OFF_TIMER_MODE);
  assign wr_tctl  = reg_wr && (reg_addr == OFF_TIMER_CTRL);
  assign wr_t0lo  = reg_wr && (reg_addr == OFF_T0_LOW);
  assign wr_t0hi  = reg_wr && (reg_addr == OFF_T0_HIGH);
  assign wr_t1lo  = reg_wr && (reg_addr == OFF_T1_LOW);
  assign wr_t1hi  = reg_wr && (reg_addr == OFF_T1_HIGH);
  assign wr_t2ctl = reg_wr && (reg_addr == OFF_THIRD_CTRL);
  assign wr_t2lo  = reg_wr && (reg_addr == OFF_THIRD_LOW);
  assign wr_t2hi  = reg_wr && (reg_addr == OFF_THIRD_HIGH);
  assign wr_rclo  = reg_wr && (reg_addr == OFF_RCAP_LOW);
  assign wr_rchi  = reg_wr && (reg_addr == OFF_RCAP_HIGH);
  assign wr_cmode = reg_wr && (reg_addr == OFF_CLOCK_MODE);

  // Machine cycle and state time ticks
  logic       six_clk, mcyc_tick, state_tick;
  logic [3:0] pre_last;
  assign six_clk    = cmode_q[CM_SIX_BIT];
  assign pre_last   = six_clk ? MCYC_LAST_6 : MCYC_LAST_12;
  assign mcyc_tick  = (pre_q >= pre_last);
  assign state_tick = six_clk | pre_q[0];

  // Timer 0/1 field decode
  logic [1:0] mode0, mode1;
  logic run0, run1, gate0, gate1, ct0, ct1, split;
  assign mode0 = timer_mode_register_q[TM_MODE0_LSB +: 2];
  assign mode1 = timer_mode_register_q[TM_MODE1_LSB +: 2];
  assign ct0   = timer_mode_register_q[TM_CT0_BIT];
  assign ct1   = timer_mode_register_q[TM_CT1_BIT];
  assign gate0 = timer_mode_register_q[TM_GATE0_BIT];
  assign gate1 = timer_mode_register_q[TM_GATE1_BIT];
  assign run0  = tctl_q[TC_RUN0_BIT];
  assign run1  = tctl_q[TC_RUN1_BIT];
  assign split = (mode0 == TTCBG_SPLIT);

  logic en0, en1, inc0, inc1, inc0h;
  assign en0  = run0 & (~gate0 | flt_q[PIN_GATE0]);
  // Under split, timer 1 loses its run bit and runs outside mode 3
  assign en1  = (split | run1) & (~gate1 | flt_q[PIN_GATE1])
              & (mode1 != TTCBG_SPLIT);
  assign inc0 = en0 & (ct0 ? fall_q[PIN_CNT0] : mcyc_tick);
  assign inc1 = en1 & (ct1 ? fall_q[PIN_CNT1] : mcyc_tick);
  assign inc0h = split & run1 & mcyc_tick;

  logic [16:0] step0, step1;
  logic [8:0]  t0h_sum;
  assign step0   = tmr_step(mode0, t0hi_q, t0lo_q, inc0);
  assign step1   = tmr_step(mode1, t1hi_q, t1lo_q, inc1);
  assign t0h_sum = {1'b0, t0hi_q} + {8'h00, inc0h};

  logic ovf0_set, ovf1_set;
  assign ovf0_set = step0[16];
  assign ovf1_set = split ? t0h_sum[8] : step1[16];

  logic [7:0] tctl_d, t0lo_d, t0hi_d, t1lo_d, t1hi_d;
  // Writes only touch the bits written; the run bit never clears counts
  assign tctl_d = {wr_tctl ? reg_wdata[7:4] : tctl_q[7:4],
                   ovf1_set | (wr_tctl ? reg_wdata[TC_OVF1_BIT]
                                       : tctl_q[TC_OVF1_BIT]),
                   wr_tctl ? reg_wdata[TC_RUN1_BIT] : tctl_q[TC_RUN1_BIT],
                   ovf0_set | (wr_tctl ? reg_wdata[TC_OVF0_BIT]
                                       : tctl_q[TC_OVF0_BIT]),
                   wr_tctl ? reg_wdata[TC_RUN0_BIT] : tctl_q[TC_RUN0_BIT]};
  assign t0lo_d = wr_t0lo ? reg_wdata : step0[7:0];
  assign t0hi_d = wr_t0hi ? reg_wdata
                : (split ? t0h_sum[7:0] : step0[15:8]);
  assign t1lo_d = wr_t1lo ? reg_wdata : step1[7:0];
  assign t1hi_d = wr_t1hi ? reg_wdata : step1[15:8];

  // Third timer decode
  logic cprl, ct2, run2, exen2, baud, trig2, inc2, ovf2;
  logic [16:0] sum2;
  assign cprl  = t2ctl_q[T2_CPRL_BIT];
  assign ct2   = t2ctl_q[T2_CT_BIT];
  assign run2  = t2ctl_q[T2_RUN_BIT];
  assign exen2 = t2ctl_q[T2_EXEN_BIT];
  assign baud  = t2ctl_q[T2_RXB_BIT] | t2ctl_q[T2_TXB_BIT];
  assign trig2 = exen2 & fall_q[PIN_TRIG2];
  assign inc2  = run2 & (ct2 ? fall_q[PIN_CLK2]
                             : (baud ? state_tick : mcyc_tick));
  assign sum2  = {1'b0, t2cnt_q} + {16'h0000, inc2};
  assign ovf2  = sum2[16];

  logic reload2, capture2;
  assign reload2  = (ovf2 & (baud | ~cprl))
                  | (trig2 & ~baud & ~cprl);
  assign capture2 = trig2 & ~baud & cprl;

  logic [15:0] t2cnt_d, rcap_d;
  logic [7:0]  t2ctl_d;
  assign t2cnt_d = {wr_t2hi ? reg_wdata : (reload2 ? rcap_q[15:8]
                                                   : sum2[15:8]),
                    wr_t2lo ? reg_wdata : (reload2 ? rcap_q[7:0]
                                                   : sum2[7:0])};
  assign rcap_d  = {wr_rchi ? reg_wdata
                            : (capture2 ? t2cnt_q[15:8] : rcap_q[15:8]),
                    wr_rclo ? reg_wdata
                            : (capture2 ? t2cnt_q[7:0] : rcap_q[7:0])};
  // Baud overflows do not raise the overflow flag
  assign t2ctl_d = {(ovf2 & ~baud) | (wr_t2ctl ? reg_wdata[T2_OVF_BIT]
                                               : t2ctl_q[T2_OVF_BIT]),
                    trig2 | (wr_t2ctl ? reg_wdata[T2_EXF_BIT]
                                      : t2ctl_q[T2_EXF_BIT]),
                    wr_t2ctl ? reg_wdata[5:0] : t2ctl_q[5:0]};

  logic bdiv_wrap;
  assign bdiv_wrap = ovf2 & baud & (bdiv_q == BAUD_DIV_LAST);

  // Read selection
  logic [7:0] rd_val;
  assign rd_val = (reg_addr == OFF_TIMER_MODE) ? timer_mode_register_q
                : (reg_addr == OFF_TIMER_CTRL) ? tctl_q
                : (reg_addr == OFF_T0_LOW)     ? t0lo_q
                : (reg_addr == OFF_T0_HIGH)    ? t0hi_q
                : (reg_addr == OFF_T1_LOW)     ? t1lo_q
                : (reg_addr == OFF_T1_HIGH)    ? t1hi_q
                : (reg_addr == OFF_THIRD_CTRL) ? t2ctl_q
                : (reg_addr == OFF_THIRD_LOW)  ? t2cnt_q[7:0]
                : (reg_addr == OFF_THIRD_HIGH) ? t2cnt_q[15:8]
                : (reg_addr == OFF_RCAP_LOW)   ? rcap_q[7:0]
                : (reg_addr == OFF_RCAP_HIGH)  ? rcap_q[15:8]
                : (reg_addr == OFF_CLOCK_MODE) ? cmode_q
                : RST_BYTE;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_mode_register_q   <= RST_BYTE;
      tctl_q   <= RST_BYTE;
      t0lo_q   <= RST_BYTE;
      t0hi_q   <= RST_BYTE;
      t1lo_q   <= RST_BYTE;
      t1hi_q   <= RST_BYTE;
      t2ctl_q  <= RST_BYTE;
      t2cnt_q  <= {RST_BYTE, RST_BYTE};
      rcap_q   <= {RST_BYTE, RST_BYTE};
      cmode_q  <= RST_BYTE;
      rdata_q  <= RST_BYTE;
      pre_q    <= 4'h0;
      bdiv_q   <= 4'h0;
      t1roll_q <= 1'b0;
      rxb_q    <= 1'b0;
      txb_q    <= 1'b0;
    end else begin
      timer_mode_register_q   <= wr_timer_mode_register ? reg_wdata : timer_mode_register_q;
      cmode_q  <= wr_cmode ? {7'h00, reg_wdata[CM_SIX_BIT]} : cmode_q;
      tctl_q   <= tctl_d;
      t0lo_q   <= t0lo_d;
      t0hi_q   <= t0hi_d;
      t1lo_q   <= t1lo_d;
      t1hi_q   <= t1hi_d;
      t2ctl_q  <= t2ctl_d;
      t2cnt_q  <= t2cnt_d;
      rcap_q   <= rcap_d;
      rdata_q  <= reg_rd ? rd_val : RST_BYTE;
      pre_q    <= mcyc_tick ? 4'h0 : pre_q + 4'h1;
      bdiv_q   <= (ovf2 & baud) ? bdiv_q + 4'h1 : bdiv_q;
      t1roll_q <= step1[16];
      rxb_q    <= bdiv_wrap & t2ctl_q[T2_RXB_BIT];
      txb_q    <= bdiv_wrap & t2ctl_q[T2_TXB_BIT];
    end
  end

  assign reg_rdata         = rdata_q;
  assign t0_overflow       = tctl_q[TC_OVF0_BIT];
  assign t1_overflow       = tctl_q[TC_OVF1_BIT];
  assign t2_overflow_flag  = t2ctl_q[T2_OVF_BIT];
  assign t2_ext_flag       = t2ctl_q[T2_EXF_BIT];
  assign t1_rollover_pulse = t1roll_q;
  assign rx_baud_tick      = rxb_q;
  assign tx_baud_tick      = txb_q;

  a_ovf0_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ovf0_set |=> t0_overflow)
    else $error("timer 0 overflow did not set its flag");

  a_gate_blocks: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (gate0 && !flt_q[PIN_GATE0] && !wr_t0lo) |=> $stable(t0lo_q))
    else $error("timer 0 counted while gated off");

  a_mode0_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode0 == TTCBG_M13 && !wr_t0lo) |=> $stable(t0lo_q[7:5]))
    else $error("mode 0 disturbed upper low bits");

  a_mode2_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode1 == TTCBG_M8AR && step1[16] && !wr_t1lo && !wr_t1hi)
    |=> (t1lo_q == $past(t1hi_q)) && $stable(t1hi_q))
    else $error("mode 2 reload wrong");

  a_t1_mode3_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode1 == TTCBG_SPLIT && !wr_t1lo && !wr_t1hi)
    |=> $stable({t1hi_q, t1lo_q}))
    else $error("timer 1 moved in mode 3");

  a_split_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (split && run1 && mcyc_tick && !wr_t0hi)
    |=> t0hi_q == $past(t0hi_q) + 8'h01)
    else $error("split high byte missed a machine cycle");

  a_t2_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ovf2 && (baud || !cprl) && !wr_t2lo && !wr_t2hi)
    |=> t2cnt_q == $past(rcap_q))
    else $error("third timer missed its reload");

  a_baud_no_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (baud && !wr_t2ctl && !t2_overflow_flag) |=> !t2_overflow_flag)
    else $error("baud overflow raised the flag");

  a_state_rate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_tick && !six_clk && !wr_cmode) |=> !state_tick)
    else $error("state time faster than half the oscillator");

  a_mcyc_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mcyc_tick && !wr_cmode) |=> !mcyc_tick[*5])
    else $error("machine cycle tick too close");

endmodule : ttcbg_top
